// *** design/wdu_osc.sv ***
`timescale 1ns/1ps
module wdu_osc
    import wdu_pkg::*;
#(
    parameter int FS_CYC = FS_CYCLES
)(
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             latch,
    input  wire logic             restart,
    input  wire logic [PER_W-1:0] resistor_period,
    input  wire logic             resistor_fault,
    output logic                  tick
);

    logic [PER_W-1:0] per;
    logic [PER_W-1:0] ph;
    logic [PER_W-1:0] next_per;
    logic [PER_W-1:0] next_ph;
    logic             next_tick;

    // Period is taken only while initialising, so a later fault cannot
    // stretch a running window
    always_comb begin
        next_per = per;
        if (latch) begin
            if (resistor_fault || resistor_period == '0) begin
                next_per = PER_W'(FS_CYC);
            end else begin
                next_per = resistor_period;
            end
        end
        next_ph   = ph + 1'b1;
        next_tick = 1'b0;
        if (restart) begin
            next_ph = '0;
        end else if (ph >= per - 1'b1) begin
            next_ph   = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            per  <= PER_W'(FS_CYC);
            ph   <= '0;
            tick <= 1'b0;
        end else begin
            per  <= next_per;
            ph   <= next_ph;
            tick <= next_tick;
        end
    end

    // A fault seen while initialising must give the fail-safe period
    fs_period_a: assert property (
        @(posedge clock) disable iff (!arst_n)
        latch && resistor_fault |=> per == PER_W'(FS_CYC))
        else $error("fail-safe period not taken");

endmodule

// *** design/wdu_pkg.sv ***
package wdu_pkg;

    // Clock rate and the power-on reset delay
    localparam int CLK_MHZ      = 200;
    localparam int POR_TIME_US  = 4000;
    localparam int POR_CYCLES   = POR_TIME_US * CLK_MHZ;

    // Fail-safe watchdog oscillator period
    localparam int FS_PERIOD_US = 50;
    localparam int FS_CYCLES    = FS_PERIOD_US * CLK_MHZ;

    // Widths of the state counter and the oscillator period
    localparam int CNT_W = 20;
    localparam int PER_W = 16;

    // Oscillator periods counted in each watchdog state
    localparam logic [CNT_W-1:0] LEAD_TICKS = 20'h01ed7;
    localparam logic [CNT_W-1:0] CW_TICKS   = 20'h0041d;
    localparam logic [CNT_W-1:0] OW_TICKS   = 20'h00451;
    localparam logic [CNT_W-1:0] RES_TICKS  = 20'h00040;

    // Reset values of the pin synchronisers
    localparam logic [2:0] TRIG_SYNC_RST = 3'h7;
    localparam logic [2:0] VCC_SYNC_RST  = 3'h0;

    typedef enum logic [4:0] {
        ST_INIT  = 5'h01,
        ST_LEAD  = 5'h02,
        ST_CLOSE = 5'h04,
        ST_OPEN  = 5'h08,
        ST_RESET = 5'h10
    } wdu_state_e;

    typedef struct packed {
        logic lead;
        logic close_win;
        logic open_win;
        logic pulse;
    } wdu_status_s;

endpackage

// *** design/wdu_watchdog.sv ***
// What this block does
// - Reset output shows watchdog state; trigger falling edge restarts timer.
// - Without triggers, reset output pulses low repeatedly at a fixed period.
// - After power-on delay, watchdog starts as the reset output rises.
// - Wake-up into standby starts the watchdog at once.
// - First state is lead, counting 7895 oscillator periods.
// - Trigger in lead enters close window of 1053 periods.
// - Close window end enters open window of 1105 periods.
// - Lead expiry without trigger enters the reset state.
// - Close window runs to its end unless a trigger (reset pulse), undervoltage or wake-up ends it, or silent-to-normal restarts it.
// - Trigger in the close window causes a reset pulse.
// - Power-on start waits for the 4 ms reset timer, then lead.
// - Wake-up start is not delayed by the reset timer.
// - VCC undervoltage clears watchdog, holds reset low, restarts after 4 ms.
// - Silent-to-normal transition starts directly in the close window.
// - Bad timing resistor seen during init forces a fail-safe period of 50 us.
// - Watchdog disabled during power-on delay, starts after reset rises.
// - Reset output reflects the window watchdog status.
`timescale 1ns/1ps
module wdu_watchdog
    import wdu_pkg::*;
#(
    parameter int                POR_CYC     = POR_CYCLES,
    parameter int                FS_CYC      = FS_CYCLES,
    parameter logic [CNT_W-1:0]  PULSE_TICKS = RES_TICKS
)(
    input  wire logic             clock,
    input  wire logic             arst_n,
    input  wire logic             wd_trigger_n,
    input  wire logic             vcc_ok,
    input  wire logic             wake_standby_entry,
    input  wire logic             silent_to_normal,
    input  wire logic [PER_W-1:0] wd_timing_resistor,
    input  wire logic             resistor_fault,
    output logic                  reset_out_n,
    output wdu_status_s           wd_status
);

    localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_CYC);

    logic [2:0]       trig_sync;
    logic [2:0]       vcc_sync;
    logic             trig_lvl;
    logic             vcc_lvl;
    logic [2:0]       next_trig_sync;
    logic [2:0]       next_vcc_sync;
    logic             next_trig_lvl;
    logic             next_vcc_lvl;
    logic             trig_fall;
    logic             tick;
    wdu_state_e       state;
    wdu_state_e       next_state;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             next_reset_out_n;
    wdu_status_s      next_status;

    // Count ends on the oscillator tick that takes it to zero
    function automatic logic expired(input logic t,
                                     input logic [CNT_W-1:0] c);
        expired = t && c == CNT_W'(1);
    endfunction

    // Pin synchronisers: a level counts once stages two and three agree,
    // which filters single-cycle glitches on the trigger line
    always_comb begin
        next_trig_sync = {trig_sync[1:0], wd_trigger_n};
        next_vcc_sync  = {vcc_sync[1:0], vcc_ok};
        next_trig_lvl  = trig_lvl;
        next_vcc_lvl   = vcc_lvl;
        if (trig_sync[1] == trig_sync[2]) begin
            next_trig_lvl = trig_sync[2];
        end
        if (vcc_sync[1] == vcc_sync[2]) begin
            next_vcc_lvl = vcc_sync[2];
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            trig_sync <= TRIG_SYNC_RST;
            vcc_sync  <= VCC_SYNC_RST;
            trig_lvl  <= 1'b1;
            vcc_lvl   <= 1'b0;
        end else begin
            trig_sync <= next_trig_sync;
            vcc_sync  <= next_vcc_sync;
            trig_lvl  <= next_trig_lvl;
            vcc_lvl   <= next_vcc_lvl;
        end
    end

    // Falling trigger edge, one cycle wide
    assign trig_fall = trig_lvl && !next_trig_lvl;

    // Oscillator restarts its phase on every state change so each
    // window counts whole periods from its entry
    wdu_osc #(
        .FS_CYC (FS_CYC)
    ) u_osc (
        .clock           (clock),
        .arst_n          (arst_n),
        .latch           (state == ST_INIT),
        .restart         (next_state != state),
        .resistor_period (wd_timing_resistor),
        .resistor_fault  (resistor_fault),
        .tick            (tick)
    );

    // Watchdog sequence; undervoltage outranks wake, wake outranks the
    // silent-to-normal start, and both outrank the running windows
    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        if (!vcc_lvl) begin
            next_state = ST_INIT;
            next_cnt   = POR_LOAD;
        end else if (wake_standby_entry) begin
            next_state = ST_LEAD;
            next_cnt   = LEAD_TICKS;
        end else if (silent_to_normal) begin
            next_state = ST_CLOSE;
            next_cnt   = CW_TICKS;
        end else begin
            unique case (state)
                ST_INIT: begin
                    // Watchdog held off during the power-on delay
                    if (cnt <= CNT_W'(1)) begin
                        next_state = ST_LEAD;
                        next_cnt   = LEAD_TICKS;
                    end else begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                ST_LEAD: begin
                    if (trig_fall) begin
                        next_state = ST_CLOSE;
                        next_cnt   = CW_TICKS;
                    end else if (expired(tick, cnt)) begin
                        next_state = ST_RESET;
                        next_cnt   = PULSE_TICKS;
                    end else if (tick) begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                ST_CLOSE: begin
                    if (trig_fall) begin
                        next_state = ST_RESET;
                        next_cnt   = PULSE_TICKS;
                    end else if (expired(tick, cnt)) begin
                        next_state = ST_OPEN;
                        next_cnt   = OW_TICKS;
                    end else if (tick) begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                ST_OPEN: begin
                    if (trig_fall) begin
                        next_state = ST_CLOSE;
                        next_cnt   = CW_TICKS;
                    end else if (expired(tick, cnt)) begin
                        next_state = ST_RESET;
                        next_cnt   = PULSE_TICKS;
                    end else if (tick) begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                ST_RESET: begin
                    // Triggers during the pulse are ignored
                    if (expired(tick, cnt)) begin
                        next_state = ST_LEAD;
                        next_cnt   = LEAD_TICKS;
                    end else if (tick) begin
                        next_cnt = cnt - 1'b1;
                    end
                end
                default: begin
                    next_state = ST_INIT;
                    next_cnt   = POR_LOAD;
                end
            endcase
        end
        // Reset output low in init and during a watchdog pulse
        next_reset_out_n = !(next_state == ST_INIT ||
                             next_state == ST_RESET);
        next_status.lead      = next_state == ST_LEAD;
        next_status.close_win = next_state == ST_CLOSE;
        next_status.open_win  = next_state == ST_OPEN;
        next_status.pulse     = next_state == ST_RESET;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state       <= ST_INIT;
            cnt         <= POR_LOAD;
            reset_out_n <= 1'b0;
            wd_status   <= '0;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            reset_out_n <= next_reset_out_n;
            wd_status   <= next_status;
        end
    end

    // Checks
    logic quiet;
    assign quiet = vcc_lvl && !wake_standby_entry && !silent_to_normal;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    lead_to_close_a: assert property (
        state == ST_LEAD && trig_fall && quiet
        |=> state == ST_CLOSE && cnt == CW_TICKS && reset_out_n)
        else $error("trigger in lead did not open close window");

    close_runs_a: assert property (
        state == ST_CLOSE && !trig_fall && !tick && quiet
        |=> state == ST_CLOSE && $stable(cnt))
        else $error("close window left or counted early");

    close_to_open_a: assert property (
        state == ST_CLOSE && !trig_fall && tick && cnt == 20'h00001
        && quiet |=> state == ST_OPEN && cnt == OW_TICKS)
        else $error("close window end did not open window");

    lead_expire_a: assert property (
        state == ST_LEAD && !trig_fall && tick && cnt == 20'h00001
        && quiet |=> state == ST_RESET && !reset_out_n)
        else $error("lead expiry did not reset");

    early_trig_a: assert property (
        state == ST_CLOSE && trig_fall && quiet
        |=> !reset_out_n ##1 !reset_out_n)
        else $error("early trigger did not pulse reset");

    uv_clear_a: assert property (
        !vcc_lvl |=> state == ST_INIT && !reset_out_n
        && cnt == POR_LOAD)
        else $error("undervoltage did not clear watchdog");

    por_release_a: assert property (
        state == ST_INIT && cnt <= 20'h00001 && quiet
        |=> $rose(reset_out_n) && state == ST_LEAD)
        else $error("power-on release did not start lead");

    wake_start_a: assert property (
        vcc_lvl && wake_standby_entry
        |=> state == ST_LEAD && cnt == LEAD_TICKS)
        else $error("wake did not start watchdog");

    silent_normal_a: assert property (
        vcc_lvl && !wake_standby_entry && silent_to_normal
        |=> state == ST_CLOSE && cnt == CW_TICKS)
        else $error("silent to normal did not start close window");

    pulse_end_a: assert property (
        state == ST_RESET && tick && cnt == 20'h00001 && quiet
        |=> state == ST_LEAD && reset_out_n)
        else $error("reset pulse end did not restart lead");

    open_miss_a: assert property (
        state == ST_OPEN && !trig_fall && tick && cnt == 20'h00001
        && quiet |=> state == ST_RESET)
        else $error("open window expiry did not reset");

    open_to_close_a: assert property (
        state == ST_OPEN && trig_fall && quiet
        |=> state == ST_CLOSE && cnt == CW_TICKS && reset_out_n)
        else $error("service in open window did not restart");

    // Holding checks: lead, init and pulse do not move without their tick or event; lead and pulse do not count without a tick
    lead_holds_a: assert property (
        state == ST_LEAD && !trig_fall && !tick && quiet
        |=> state == ST_LEAD && $stable(cnt))
        else $error("lead left or counted without a tick");

    init_holds_a: assert property (
        state == ST_INIT && cnt > 20'h00001 && quiet
        |=> state == ST_INIT && !reset_out_n)
        else $error("watchdog ran during power-on delay");

    pulse_holds_a: assert property (
        state == ST_RESET && !tick && quiet
        |=> state == ST_RESET && !reset_out_n && $stable(cnt))
        else $error("reset pulse cut short");

    status_pin_a: assert property (
        reset_out_n == (wd_status.lead || wd_status.close_win
        || wd_status.open_win))
        else $error("reset output disagrees with status");

    good_service_c: cover property (
        state == ST_OPEN && trig_fall ##1 state == ST_CLOSE);
    early_trig_c: cover property (
        state == ST_CLOSE && trig_fall ##1 state == ST_RESET);
    lead_expire_c: cover property (
        state == ST_LEAD ##1 state == ST_RESET);
    uv_event_c: cover property ($fell(vcc_lvl));
    wake_start_c: cover property (vcc_lvl && wake_standby_entry);

endmodule

// *** sim/wdu_host.sv ***
`timescale 1ns/1ps
module wdu_host (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        fire,
    input  wire logic        auto_serve,
    input  wire logic [15:0] serve_delay,
    input  wire logic        open_win,
    output logic             wd_trigger_n
);
    logic [15:0] wait_cnt;
    logic [15:0] next_wait_cnt;
    logic [3:0]  low_cnt;
    logic [3:0]  next_low_cnt;
    logic        next_trigger_n;

    // Low for four cycles, then high for at least five, so the pin is settled
    // before any further fall; the pin rests high as if pulled up
    always_comb begin
        next_wait_cnt = (auto_serve && open_win) ? wait_cnt + 16'h0001
                                                 : 16'h0000;
        next_low_cnt  = (low_cnt != 4'h0) ? low_cnt - 4'h1 : 4'h0;
        if (low_cnt == 4'h0 && fire) begin
            next_low_cnt = 4'h8;
        end
        // Serve only inside the open window, after the chosen delay
        if (low_cnt == 4'h0 && auto_serve && open_win
            && wait_cnt == serve_delay) begin
            next_low_cnt = 4'h8;
        end
        next_trigger_n = !(next_low_cnt > 4'h4);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt     <= 16'h0000;
            low_cnt      <= 4'h0;
            wd_trigger_n <= 1'b1;
        end else begin
            wait_cnt     <= next_wait_cnt;
            low_cnt      <= next_low_cnt;
            wd_trigger_n <= next_trigger_n;
        end
    end
endmodule

// *** sim/wdu_watchdog_tb.sv ***
`timescale 1ns/1ps
module wdu_watchdog_tb;
    import wdu_pkg::*;
    // Status bit positions, and 4 standing for the reset output
    localparam int LD = 3, CW = 2, OW = 1, PL = 0, RO = 4;
    logic             clock, arst_n, vcc_ok, wake_standby_entry;
    logic             silent_to_normal, resistor_fault, reset_out_n;
    logic             wd_trigger_n, fire, auto_serve;
    logic [PER_W-1:0] wd_timing_resistor;
    logic [15:0]      serve_delay;
    wdu_status_s      wd_status;
    int               n_errors, compares;

    // Short power-on delay and pulse keep the run brief
    wdu_watchdog #(.POR_CYC(50), .FS_CYC(8), .PULSE_TICKS(20'h00004))
        wdu_watchdog_inst (
        .clock(clock), .arst_n(arst_n), .wd_trigger_n(wd_trigger_n),
        .vcc_ok(vcc_ok), .wake_standby_entry(wake_standby_entry),
        .silent_to_normal(silent_to_normal),
        .wd_timing_resistor(wd_timing_resistor),
        .resistor_fault(resistor_fault), .reset_out_n(reset_out_n),
        .wd_status(wd_status));

    wdu_host wdu_host_inst (
        .clock(clock), .arst_n(arst_n), .fire(fire),
        .auto_serve(auto_serve), .serve_delay(serve_delay),
        .open_win(wd_status.open_win), .wd_trigger_n(wd_trigger_n));

    always #2.5 clock = ~clock;

    task automatic tally_and_finish();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    function automatic logic cur(input int idx);
        if (idx == RO) return reset_out_n;
        return wd_status[idx];
    endfunction

    // Cycles until the watched bit takes the value, capped at lim
    task automatic wait_st(input int idx, input logic v, input int lim,
                           output int c);
        c = 0;
        while (cur(idx) !== v && c < lim) begin
            @(posedge clock);
            #1;
            c++;
        end
    endtask

    task automatic fire_trig();
        @(posedge clock);
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
    endtask

    task automatic t_power_on();
        int c;
        wait_st(RO, 1'b1, 200, c);
        check(c >= 50 && c <= 62, "power-on delay length");
        check(wd_status.lead === 1'b1, "no lead at release");
    endtask

    // Period of 2 cycles: lead is 2*7895+1 cycles, pulse 4 ticks
    task automatic t_lead_expiry();
        int c;
        wait_st(PL, 1'b1, 16000, c);
        check(c >= 15780 && c <= 15805, "lead length");
        check(reset_out_n === 1'b0, "reset not low");
        wait_st(RO, 1'b1, 50, c);
        check(c >= 7 && c <= 13, "reset pulse width");
        check(wd_status.lead === 1'b1, "no lead after pulse");
    endtask

    task automatic t_windows();
        int c;
        fire_trig();
        wait_st(CW, 1'b1, 12, c);
        check(c < 12, "lead trigger ignored");
        wait_st(OW, 1'b1, 2200, c);
        check(c >= 2100 && c <= 2115, "close window length");
        wait_st(PL, 1'b1, 2300, c);
        check(c >= 2200 && c <= 2220, "open window expiry");
        wait_st(LD, 1'b1, 30, c);
        check(c < 30, "no restart after pulse");
    endtask

    task automatic t_close_trigger();
        int c;
        fire_trig();
        wait_st(CW, 1'b1, 12, c);
        check(c < 12, "lead trigger ignored");
        repeat (100) @(posedge clock);
        fire_trig();
        wait_st(PL, 1'b1, 12, c);
        check(c < 12, "early trigger not punished");
        check(reset_out_n === 1'b0, "reset not low");
        wait_st(LD, 1'b1, 30, c);
        check(c < 30, "no restart after pulse");
    endtask

    // Prompt and then slow service inside the open window
    task automatic t_open_service();
        int c;
        @(posedge clock);
        auto_serve  <= 1'b1;
        serve_delay <= 16'h03e8;
        fire_trig();
        wait_st(OW, 1'b1, 2300, c);
        check(c < 2300, "open window not reached");
        wait_st(CW, 1'b1, 1100, c);
        check(c >= 995 && c <= 1015, "prompt service lost");
        check(reset_out_n === 1'b1, "reset on good service");
        @(posedge clock);
        serve_delay <= 16'h07d0;
        wait_st(OW, 1'b1, 2200, c);
        check(c < 2200, "open window not reached");
        wait_st(CW, 1'b1, 2100, c);
        check(c >= 1995 && c <= 2015, "slow service lost");
        @(posedge clock);
        auto_serve <= 1'b0;
        wait_st(PL, 1'b1, 4500, c);
        check(c < 4500, "missed service not punished");
        wait_st(LD, 1'b1, 30, c);
        check(c < 30, "no reset cycle after missed service");
    endtask

    task automatic t_undervoltage();
        int c;
        @(posedge clock);
        vcc_ok <= 1'b0;
        wait_st(RO, 1'b0, 10, c);
        check(c < 10, "undervoltage not seen");
        @(posedge clock);
        #1;
        check(reset_out_n === 1'b0, "reset not held");
        check(wd_status === wdu_status_s'(4'h0), "not cleared");
        repeat (20) @(posedge clock);
        resistor_fault <= 1'b1;
        vcc_ok         <= 1'b1;
        wait_st(RO, 1'b1, 200, c);
        check(c >= 50 && c <= 62, "recovery delay");
        check(wd_status.lead === 1'b1, "no lead on recovery");
    endtask

    // Fault latched in the last start-up gives 8-cycle ticks
    task automatic t_fail_safe();
        int c;
        @(posedge clock);
        silent_to_normal <= 1'b1;
        @(posedge clock);
        silent_to_normal <= 1'b0;
        wait_st(CW, 1'b1, 4, c);
        check(c <= 3, "close window not entered");
        wait_st(OW, 1'b1, 8500, c);
        check(c >= 8410 && c <= 8440, "fail-safe period");
        @(posedge clock);
        resistor_fault <= 1'b0;
    endtask

    task automatic t_wake();
        int c;
        @(posedge clock);
        vcc_ok             <= 1'b0;
        wd_timing_resistor <= 16'h0000;
        repeat (20) @(posedge clock);
        vcc_ok <= 1'b1;
        repeat (10) @(posedge clock);
        wake_standby_entry <= 1'b1;
        @(posedge clock);
        wake_standby_entry <= 1'b0;
        wait_st(LD, 1'b1, 5, c);
        check(c <= 3, "wake start delayed");
        check(reset_out_n === 1'b1, "reset held on wake");
        // Zero period latched in init falls back to the fail-safe period
        @(posedge clock);
        silent_to_normal <= 1'b1;
        @(posedge clock);
        silent_to_normal <= 1'b0;
        wait_st(OW, 1'b1, 8500, c);
        check(c >= 8410 && c <= 8440, "zero period not fail-safe");
    endtask

    // Whole run needs about 50000 cycles
    initial begin
        repeat (80000) @(posedge clock);
        n_errors++;
        $display("mismatch at %0t: run hung", $time);
        tally_and_finish();
    end

    initial begin
        clock              = 1'b0;
        arst_n             = 1'b0;
        vcc_ok             = 1'b1;
        wake_standby_entry = 1'b0;
        silent_to_normal   = 1'b0;
        resistor_fault     = 1'b0;
        fire               = 1'b0;
        auto_serve         = 1'b0;
        serve_delay        = 16'h0000;
        wd_timing_resistor = 16'h0002;
        n_errors           = 0;
        compares           = 0;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        t_power_on();
        t_lead_expiry();
        t_windows();
        t_close_trigger();
        t_open_service();
        t_undervoltage();
        t_fail_safe();
        t_wake();
        tally_and_finish();
    end
endmodule
